// *** shared/rbsb_defines.vh ***
`ifndef RBSB_DEFINES_VH
`define RBSB_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define RBSB_CLK_KHZ        25000
`define RBSB_STROBE_MAX_MS  10
`define RBSB_ONESHOT_CYC    8'h10

// ----------------------------------------
// block and check word layout
// ----------------------------------------
`define RBSB_BLK_W          26
`define RBSB_SYN_W          10
`define RBSB_DATA_W         16
`define RBSB_WORD_W         19
`define RBSB_POLY           11'h5B9

// ----------------------------------------
// offset syndromes per block kind
// ----------------------------------------
`define RBSB_OFS_A          10'h0FC
`define RBSB_OFS_B          10'h198
`define RBSB_OFS_C          10'h168
`define RBSB_OFS_CP         10'h350
`define RBSB_OFS_D          10'h1B4
`define RBSB_OFS_E          10'h000

// ----------------------------------------
// block identifiers
// ----------------------------------------
`define RBSB_ID_A           3'h0
`define RBSB_ID_B           3'h1
`define RBSB_ID_C           3'h2
`define RBSB_ID_CP          3'h3
`define RBSB_ID_D           3'h4
`define RBSB_ID_E           3'h5

// ----------------------------------------
// data-available modes
// ----------------------------------------
`define RBSB_MODE_NORMAL    2'h0
`define RBSB_MODE_FAST      2'h1
`define RBSB_MODE_HALF      2'h2

// ----------------------------------------
// buffer and reset values
// ----------------------------------------
`define RBSB_FIFO_DEPTH     8
`define RBSB_FIFO_AW        3
`define RBSB_CNT_RST        6'h00

`endif

// *** hw/rbsb_fifo.v ***
`timescale 1ns/1ns
`default_nettype none

module rbsb_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers wrap on depth, not on a power of two
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/rbsb_oneshot.v ***
`timescale 1ns/1ns
`default_nettype none

module rbsb_oneshot #(
  parameter [7:0] LEN = 8'h10
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // trigger and pulse
  input  wire trig,
  output reg  pulse
);

  reg [7:0] cnt_r;

  // a new trigger restarts the full width
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      pulse <= 1'b0;
    end else if (trig) begin
      cnt_r <= LEN - 8'h01;
      pulse <= 1'b1;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** hw/rbsb_top.v ***
// Contract
// - interrupt line pulled low while any enabled flag is set.
// - normal mode: each new block transferred, data-ready set, interrupt.
// - data-ready clears on read of decoded data, holds while unread.
// - new block shifts newest into older, loads newest, pulses interrupt.
// - overflow set when two unread blocks sit in newest and older.
// - timely read lets buffered block shift into newest at once.
// - overflow clears on newest read; host reads overflow first.
// - fast mode search: data-ready only after valid A or C' block.
// - two good blocks in valid order declare lock and interrupt.
// - fast mode, missing B: next A or C' decoded, kept in history.
// - fast mode, locked: every decoded block sets data-ready, interrupts.
// - half rate: like normal, data-ready only after two new blocks.
// - host thresholds 0..63, search limit 0..63, counts 0..63 readable.
// - unlocked: sliding 26-bit syndrome, then check following 26 bits.
// - bad expected block bumps search counter; at limit restart search.
// - RBDS with first block E: always expect A next.
// - locked: bad count +1 per bad block; at threshold lose lock.
// - good count only while locked; at threshold both counts cleared.
// - overflow clears on read or new-search command, which restarts search.
// - each decoded block drives strobe low; fires one-shot if masked in.
// - lock-lost flag clears on read of interrupt flag byte.
// - lock-lost mask set: idle until new search; clear: auto restart.
// - strobe released on last byte read or after 10 ms low.
// - updates held off from first to last decoded byte read.
`timescale 1ns/1ns
`default_nettype none
`include "rbsb_defines.vh"

module rbsb_top #(
  parameter [17:0] STROBE_MAX_CYC = `RBSB_STROBE_MAX_MS * `RBSB_CLK_KHZ
) (
  // clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // demodulated bit stream
  input  wire                    bit_in,
  input  wire                    bit_stb,
  output reg                     bit_ready_r,
  // configuration
  input  wire [1:0]              dav_mode,
  input  wire                    rbds_en,
  input  wire                    data_ready_mask,
  input  wire                    lock_lost_mask,
  input  wire [5:0]              bad_loss_threshold,
  input  wire [5:0]              good_reset_threshold,
  input  wire [5:0]              search_bad_limit,
  input  wire                    new_search_cmd,
  // host read strobes
  input  wire                    rd_irq_flag_byte,
  input  wire                    rd_first_decoded_byte,
  input  wire                    rd_last_decoded_byte,
  // status and data
  output reg                     data_ready_flag_r,
  output reg                     overflow_flag_r,
  output reg                     lock_lost_flag_r,
  output reg                     lock_r,
  output reg                     new_word_strobe_n_r,
  output reg  [5:0]              good_count_r,
  output reg  [5:0]              bad_count_r,
  output reg  [`RBSB_WORD_W-1:0] newest_word_reg_r,
  output reg  [`RBSB_WORD_W-1:0] older_word_reg_r,
  // open-drain interrupt line
  input  wire                    irq_in,
  output reg                     irq_out_n_r,
  output reg                     irq_oe_r,
  output reg                     irq_line_low_r
);

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function [`RBSB_SYN_W-1:0] syndrome;
    input [`RBSB_BLK_W-1:0] v;
    reg   [`RBSB_BLK_W-1:0] t;
    integer i;
    begin
      t = v;
      for (i = `RBSB_BLK_W - 1; i >= `RBSB_SYN_W; i = i - 1) begin
        if (t[i]) begin
          t = t ^ ({15'h0000, `RBSB_POLY} << (i - `RBSB_SYN_W));
        end
      end
      syndrome = t[`RBSB_SYN_W-1:0];
    end
  endfunction

  // {valid, id}
  function [3:0] blk_id;
    input [`RBSB_SYN_W-1:0] s;
    begin
      case (s)
        `RBSB_OFS_A:  blk_id = {1'b1, `RBSB_ID_A};
        `RBSB_OFS_B:  blk_id = {1'b1, `RBSB_ID_B};
        `RBSB_OFS_C:  blk_id = {1'b1, `RBSB_ID_C};
        `RBSB_OFS_CP: blk_id = {1'b1, `RBSB_ID_CP};
        `RBSB_OFS_D:  blk_id = {1'b1, `RBSB_ID_D};
        `RBSB_OFS_E:  blk_id = {1'b1, `RBSB_ID_E};
        default:      blk_id = 4'h0;
      endcase
    end
  endfunction

  function [2:0] next_id;
    input [2:0] id;
    begin
      case (id)
        `RBSB_ID_A:  next_id = `RBSB_ID_B;
        `RBSB_ID_B:  next_id = `RBSB_ID_C;
        `RBSB_ID_C:  next_id = `RBSB_ID_D;
        `RBSB_ID_CP: next_id = `RBSB_ID_D;
        `RBSB_ID_D:  next_id = `RBSB_ID_A;
        default:     next_id = `RBSB_ID_E;
      endcase
    end
  endfunction

  // a slot expecting C also takes C'
  function id_match;
    input [2:0] got;
    input [2:0] exp;
    begin
      id_match = (got == exp) | ((exp == `RBSB_ID_C) & (got == `RBSB_ID_CP));
    end
  endfunction

  function is_pi_blk;
    input [2:0] id;
    begin
      is_pi_blk = (id == `RBSB_ID_A) | (id == `RBSB_ID_CP);
    end
  endfunction

  // ----------------------------------------
  // synchroniser state
  // ----------------------------------------
  localparam [1:0] ST_SEARCH = 2'h0;
  localparam [1:0] ST_VERIFY = 2'h1;
  localparam [1:0] ST_LOCKED = 2'h2;
  localparam [1:0] ST_IDLE   = 2'h3;

  reg  [1:0]              state_r;
  reg  [`RBSB_BLK_W-1:0]  win_r;
  reg  [4:0]              bitcnt_r;
  reg  [2:0]              expect_r;
  reg                     first_e_r;
  reg  [5:0]              search_bad_r;
  reg                     sync_evt_r;
  reg                     lost_evt_r;

  wire                    take;
  wire [`RBSB_BLK_W-1:0]  win_nxt;
  wire [3:0]              idv;
  wire                    boundary;
  wire                    good;
  wire                    fast;
  wire                    push_req;
  wire                    fifo_in_ready;
  wire [`RBSB_WORD_W-1:0] push_word;

  assign take      = bit_stb & bit_ready_r;
  assign win_nxt   = {win_r[`RBSB_BLK_W-2:0], bit_in};
  // e blocks exist only in rbds; a zero window must not look like one
  assign idv       = blk_id(syndrome(win_nxt)) & {rbds_en | (syndrome(win_nxt) != `RBSB_OFS_E), 3'h7};
  assign boundary  = (bitcnt_r == 5'h19);
  assign good      = idv[3] & id_match(idv[2:0], expect_r);
  assign fast      = (dav_mode == `RBSB_MODE_FAST);
  assign push_word = {idv[2:0], win_nxt[`RBSB_BLK_W-1:`RBSB_SYN_W]};

  // while unlocked only fast mode delivers, and only PI blocks; the block that confirms lock is delivered in every mode
  assign push_req = take & (
    ((state_r == ST_SEARCH) & fast & idv[3] & is_pi_blk(idv[2:0])) |
    ((state_r == ST_VERIFY) & boundary &
      (good | (fast & idv[3] & is_pi_blk(idv[2:0])))) |
    ((state_r == ST_LOCKED) & boundary & good));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r      <= ST_SEARCH;
      win_r        <= {`RBSB_BLK_W{1'b0}};
      bitcnt_r     <= 5'h00;
      expect_r     <= `RBSB_ID_A;
      first_e_r    <= 1'b0;
      search_bad_r <= `RBSB_CNT_RST;
      lock_r       <= 1'b0;
      good_count_r <= `RBSB_CNT_RST;
      bad_count_r  <= `RBSB_CNT_RST;
      sync_evt_r   <= 1'b0;
      lost_evt_r   <= 1'b0;
    end else begin
      sync_evt_r <= 1'b0;
      lost_evt_r <= 1'b0;
      if (new_search_cmd) begin
        state_r      <= ST_SEARCH;
        lock_r       <= 1'b0;
        good_count_r <= `RBSB_CNT_RST;
        bad_count_r  <= `RBSB_CNT_RST;
      end else if (take) begin
        win_r    <= win_nxt;
        bitcnt_r <= boundary ? 5'h00 : bitcnt_r + 5'h01;
        case (state_r)
          ST_SEARCH: begin
            if (idv[3]) begin
              state_r      <= ST_VERIFY;
              bitcnt_r     <= 5'h00;
              search_bad_r <= `RBSB_CNT_RST;
              first_e_r    <= rbds_en & (idv[2:0] == `RBSB_ID_E);
              expect_r     <= (rbds_en & (idv[2:0] == `RBSB_ID_E)) ? `RBSB_ID_A : next_id(idv[2:0]);
            end
          end
          ST_VERIFY: begin
            if (boundary) begin
              if (good) begin
                state_r      <= ST_LOCKED;
                lock_r       <= 1'b1;
                sync_evt_r   <= 1'b1;
                good_count_r <= `RBSB_CNT_RST;
                bad_count_r  <= `RBSB_CNT_RST;
                expect_r     <= next_id(idv[2:0]);
              end else if (search_bad_r + 6'h01 >= search_bad_limit) begin
                state_r <= ST_SEARCH;
              end else begin
                search_bad_r <= search_bad_r + 6'h01;
                expect_r     <= first_e_r ? `RBSB_ID_A : next_id(expect_r);
              end
            end
          end
          ST_LOCKED: begin
            if (boundary) begin
              expect_r <= next_id(good ? idv[2:0] : expect_r);
              if (good) begin
                if (good_count_r + 6'h01 == good_reset_threshold) begin
                  good_count_r <= `RBSB_CNT_RST;
                  bad_count_r  <= `RBSB_CNT_RST;
                end else begin
                  good_count_r <= good_count_r + 6'h01;
                end
              end else if (bad_count_r + 6'h01 == bad_loss_threshold) begin
                lock_r      <= 1'b0;
                bad_count_r <= bad_count_r + 6'h01;
                lost_evt_r  <= lock_lost_mask;
                state_r     <= lock_lost_mask ? ST_IDLE : ST_SEARCH;
              end else begin
                bad_count_r <= bad_count_r + 6'h01;
              end
            end
          end
          ST_IDLE: begin
            state_r <= ST_IDLE;
          end
          default: begin
            state_r <= ST_SEARCH;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // decoder buffer
  // ----------------------------------------
  wire                    buf_valid;
  wire                    buf_ready;
  wire [`RBSB_WORD_W-1:0] buf_word;

  rbsb_fifo #(
    .WIDTH (`RBSB_WORD_W),
    .DEPTH (`RBSB_FIFO_DEPTH),
    .AW    (`RBSB_FIFO_AW)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );

  // ----------------------------------------
  // host-visible word registers and flags
  // ----------------------------------------
  reg         rd_busy_r;
  reg  [1:0]  unread_r;
  reg         pair_r;
  reg  [17:0] strobe_cnt_r;
  wire        xfer;
  wire        rd_done;

  // with two words unread the buffer is held so nothing is overwritten
  assign buf_ready = ~rd_busy_r & (unread_r != 2'h2);
  assign xfer      = buf_valid & buf_ready;
  assign rd_done   = rd_last_decoded_byte;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_busy_r           <= 1'b0;
      unread_r            <= 2'h0;
      pair_r              <= 1'b0;
      newest_word_reg_r   <= {`RBSB_WORD_W{1'b0}};
      older_word_reg_r    <= {`RBSB_WORD_W{1'b0}};
      data_ready_flag_r   <= 1'b0;
      overflow_flag_r     <= 1'b0;
      lock_lost_flag_r    <= 1'b0;
      new_word_strobe_n_r <= 1'b1;
      strobe_cnt_r        <= 18'h00000;
      bit_ready_r         <= 1'b0;
    end else begin
      bit_ready_r <= fifo_in_ready & ~push_req;
      if (rd_first_decoded_byte) begin
        rd_busy_r <= 1'b1;
      end else if (rd_done) begin
        rd_busy_r <= 1'b0;
      end
      // clears first, then sets: an event in the clearing cycle wins
      if (rd_done) begin
        unread_r          <= 2'h0;
        pair_r            <= 1'b0;
        data_ready_flag_r <= 1'b0;
        overflow_flag_r   <= 1'b0;
      end
      if (new_search_cmd) begin
        overflow_flag_r <= 1'b0;
      end
      if (rd_irq_flag_byte) begin
        lock_lost_flag_r <= 1'b0;
      end
      if (lost_evt_r) begin
        lock_lost_flag_r <= 1'b1;
      end
      if (~new_word_strobe_n_r) begin
        strobe_cnt_r <= strobe_cnt_r + 18'h00001;
        if (rd_done | (strobe_cnt_r == STROBE_MAX_CYC - 18'h00001)) begin
          new_word_strobe_n_r <= 1'b1;
        end
      end
      if (xfer) begin
        older_word_reg_r    <= newest_word_reg_r;
        newest_word_reg_r   <= buf_word;
        new_word_strobe_n_r <= 1'b0;
        strobe_cnt_r        <= 18'h00000;
        unread_r            <= rd_done ? 2'h1 : unread_r + 2'h1;
        pair_r              <= rd_done ? 1'b1 : ~pair_r;
        if (~rd_done & (unread_r == 2'h1)) begin
          overflow_flag_r <= 1'b1;
        end
        if ((dav_mode != `RBSB_MODE_HALF) | (~rd_done & pair_r)) begin
          data_ready_flag_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt one-shot and open-drain line
  // ----------------------------------------
  reg  strobe_d_r;
  wire os_pulse;
  wire os_trig;

  assign os_trig = (strobe_d_r & ~new_word_strobe_n_r & data_ready_mask) | sync_evt_r | lost_evt_r;

  rbsb_oneshot #(
    .LEN (`RBSB_ONESHOT_CYC)
  ) u_oneshot (
    .clk   (clk),
    .rst   (rst),
    .trig  (os_trig),
    .pulse (os_pulse)
  );

  // the pin only ever sinks; the pull-up makes the high level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_d_r     <= 1'b1;
      irq_out_n_r    <= 1'b0;
      irq_oe_r       <= 1'b0;
      irq_line_low_r <= 1'b0;
    end else begin
      strobe_d_r     <= new_word_strobe_n_r;
      irq_out_n_r    <= 1'b0;
      irq_oe_r       <= os_pulse | (data_ready_flag_r & data_ready_mask) |
                        (lock_lost_flag_r & lock_lost_mask);
      irq_line_low_r <= ~irq_in;
    end
  end

endmodule

`default_nettype wire

// *** test/rbsb_top_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rbsb_defines.vh"

module rbsb_top_asserts #(
  parameter [17:0] STROBE_MAX_CYC = 18'h3D090
) (
  // clock and reset
  input wire                    clk,
  input wire                    rst,
  // watched inputs
  input wire                    data_ready_mask,
  input wire                    lock_lost_mask,
  input wire                    new_search_cmd,
  input wire                    rd_irq_flag_byte,
  input wire                    rd_first_decoded_byte,
  input wire                    rd_last_decoded_byte,
  input wire                    irq_in,
  // watched outputs
  input wire                    data_ready_flag_r,
  input wire                    overflow_flag_r,
  input wire                    lock_lost_flag_r,
  input wire                    lock_r,
  input wire                    new_word_strobe_n_r,
  input wire [5:0]              good_count_r,
  input wire [`RBSB_WORD_W-1:0] newest_word_reg_r,
  input wire [`RBSB_WORD_W-1:0] older_word_reg_r,
  input wire                    irq_out_n_r,
  input wire                    irq_oe_r,
  input wire                    irq_line_low_r
);
  reg [17:0] low_cnt_r;
  reg        frz_r;

  // ----------------------------------------
  // helpers: strobe low time, host read window
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 18'h00000;
      frz_r     <= 1'b0;
    end else begin
      low_cnt_r <= new_word_strobe_n_r ? 18'h00000 : low_cnt_r + 18'h00001;
      frz_r     <= rd_last_decoded_byte ? 1'b0 : (rd_first_decoded_byte ? 1'b1 : frz_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_irq_data_drive: assert property (data_ready_flag_r && data_ready_mask |=> irq_oe_r)
    else $error("irq line not pulled for masked data flag");
  a_od_low_only: assert property (irq_oe_r |-> !irq_out_n_r)
    else $error("open drain output not low while enabled");
  a_line_sense: assert property (!$past(rst) |-> irq_line_low_r == !$past(irq_in))
    else $error("sensed line level wrong");
  a_ovf_two_words: assert property ($rose(overflow_flag_r) |->
    data_ready_flag_r && older_word_reg_r == $past(newest_word_reg_r))
    else $error("overflow without two unread words");
  a_read_clears: assert property (rd_last_decoded_byte |=>
    !data_ready_flag_r && !overflow_flag_r && new_word_strobe_n_r)
    else $error("last byte read did not clear flags");
  a_freeze_hold: assert property (frz_r && !rd_last_decoded_byte && !new_search_cmd |=>
    $stable(newest_word_reg_r) && $stable(older_word_reg_r))
    else $error("words changed during host read");
  a_shift_older: assert property (!$stable(newest_word_reg_r) && !$past(new_search_cmd) |->
    older_word_reg_r == $past(newest_word_reg_r))
    else $error("older word is not previous newest");
  a_loss_flag_set: assert property ($fell(lock_r) && lock_lost_mask && !$past(new_search_cmd) |->
    ##[0:1] lock_lost_flag_r)
    else $error("lock loss not flagged");
  a_flag_byte_clr: assert property (rd_irq_flag_byte |=> !lock_lost_flag_r)
    else $error("flag byte read left lock lost flag");
  a_search_cmd: assert property (new_search_cmd |=> !overflow_flag_r && !lock_r)
    else $error("new search left overflow or lock");
  a_strobe_max: assert property (low_cnt_r <= STROBE_MAX_CYC + 18'h00001)
    else $error("strobe held low too long");
  a_good_locked: assert property (good_count_r == $past(good_count_r) + 6'h01 |-> $past(lock_r))
    else $error("good count grew while unlocked");
endmodule

bind rbsb_top rbsb_top_asserts #(.STROBE_MAX_CYC(STROBE_MAX_CYC)) u_chk (.*);

`default_nettype wire

// *** test/rbsb_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module rbsb_host_model (
  // clock
  input wire clk,
  // wired-or line
  input wire irq_oe_r,
  input wire other_low,
  output wire irq_in,
  // read strobes
  output reg  rd_first,
  output reg  rd_last,
  output reg  rd_flag
);
  // pull-up wins unless some party sinks the line
  assign irq_in = !(irq_oe_r || other_low);

  initial begin
    rd_first = 1'b0;
    rd_last  = 1'b0;
    rd_flag  = 1'b0;
  end

  task freeze;
    begin
      @(negedge clk) rd_first = 1'b1;
      @(negedge clk) rd_first = 1'b0;
    end
  endtask

  task unfreeze;
    begin
      @(negedge clk) rd_last = 1'b1;
      @(negedge clk) rd_last = 1'b0;
    end
  endtask

  // all eight bytes in one action, well before the next block
  task read_data;
    begin
      freeze;
      repeat (3) @(negedge clk);
      unfreeze;
    end
  endtask

  task read_flags;
    begin
      @(negedge clk) rd_flag = 1'b1;
      @(negedge clk) rd_flag = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rbsb_defines.vh"

module testbench;
  reg         clk, rst, bit_in, bit_stb, rbds_en, dr_mask, ll_mask, nws, other_low, ok;
  reg  [1:0]  dav_mode;
  reg  [5:0]  bl_th, gr_th, sb_lim;
  wire        bit_ready_r, drf, ovf, llf, lock_r, stb_n, irq_in, irq_n, irq_oe, line_low;
  wire        rd_first, rd_last, rd_flag;
  wire [5:0]  good_c, bad_c;
  wire [18:0] newest, older;
  integer     num_errors, cmp_count, cyc, g, n;

  always #20 clk = ~clk;

  rbsb_top #(.STROBE_MAX_CYC(18'h00014)) i_rbsb_top (.clk(clk), .rst(rst), .bit_in(bit_in),
    .bit_stb(bit_stb), .bit_ready_r(bit_ready_r), .dav_mode(dav_mode), .rbds_en(rbds_en),
    .data_ready_mask(dr_mask), .lock_lost_mask(ll_mask), .bad_loss_threshold(bl_th),
    .good_reset_threshold(gr_th), .search_bad_limit(sb_lim), .new_search_cmd(nws),
    .rd_irq_flag_byte(rd_flag), .rd_first_decoded_byte(rd_first), .rd_last_decoded_byte(rd_last),
    .data_ready_flag_r(drf), .overflow_flag_r(ovf), .lock_lost_flag_r(llf), .lock_r(lock_r),
    .new_word_strobe_n_r(stb_n), .good_count_r(good_c), .bad_count_r(bad_c),
    .newest_word_reg_r(newest), .older_word_reg_r(older), .irq_in(irq_in),
    .irq_out_n_r(irq_n), .irq_oe_r(irq_oe), .irq_line_low_r(line_low));

  rbsb_host_model i_rbsb_host_model (.clk(clk), .irq_oe_r(irq_oe), .other_low(other_low),
    .irq_in(irq_in), .rd_first(rd_first), .rd_last(rd_last), .rd_flag(rd_flag));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [9:0] crc(input [15:0] d);
    integer k;
    begin
      crc = 10'h000;
      for (k = 15; k >= 0; k = k - 1)
        crc = {crc[8:0], 1'b0} ^ ((crc[9] ^ d[k]) ? 10'h1B9 : 10'h000);
    end
  endfunction

  function [2:0] idof(input integer k);
    idof = (k[1:0] == 2'h3) ? `RBSB_ID_D : {1'b0, k[1:0]};
  endfunction

  function [18:0] wd(input integer k);
    wd = {idof(k), 16'h1000 + k[15:0]};
  endfunction

  function [9:0] ofs(input [2:0] id);
    case (id)
      `RBSB_ID_A: ofs = `RBSB_OFS_A;
      `RBSB_ID_B: ofs = `RBSB_OFS_B;
      `RBSB_ID_C: ofs = `RBSB_OFS_C;
      default:    ofs = `RBSB_OFS_D;
    endcase
  endfunction

  task chk(input string nm, input [18:0] e, input [18:0] v);
    begin
      cmp_count = cmp_count + 1;
      if (v !== e) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", nm, e, v);
      end
    end
  endtask

  task st;
    repeat (3) @(negedge clk);
  endtask

  // block g of the A B C D cycle, msb first; refused when the buffer stays full
  task nb(input bad);
    reg [25:0] b;
    integer    i, w;
    begin
      b = {wd(g), 7'h00} << 3;
      b[9:0] = crc(b[25:10]) ^ ofs(idof(g)) ^ (bad ? 10'h3FF : 10'h000);
      ok = 1'b1;
      for (i = 25; i >= 0; i = i - 1) begin
        w = 0;
        while (ok && !bit_ready_r && w < 60) begin
          bit_stb = 1'b0;
          @(negedge clk);
          w = w + 1;
        end
        if (ok && bit_ready_r) begin
          bit_in = b[i];
          bit_stb = 1'b1;
          @(negedge clk);
        end else begin
          ok = 1'b0;
        end
      end
      bit_stb = 1'b0;
      if (ok)
        g = g + 1;
    end
  endtask

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // ~1000 cycles expected; hang guard well above it
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {clk, bit_in, bit_stb, rbds_en, nws, other_low} = 6'h00;
    {rst, dr_mask, ll_mask} = 3'h7;
    dav_mode = `RBSB_MODE_NORMAL;
    {bl_th, gr_th, sb_lim} = {6'h02, 6'h3F, 6'h02};
    {num_errors, cmp_count, cyc, g} = 128'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("reset flags", 19'h0, {lock_r, drf, ovf, llf, ~stb_n, irq_oe, irq_n});
    chk("reset newest", 19'h0, newest);
    $display("test reset done");

    while (g < 6) nb(1'b0);
    st;
    chk("lock", 19'h1, lock_r);
    repeat (3) begin i_rbsb_host_model.read_data; st; end
    chk("drained", 19'h0, drf);
    nb(1'b0);
    st;
    chk("newest", wd(g - 1), newest);
    chk("strobe", 19'h0, stb_n);
    chk("data ready", 19'h1, drf);
    chk("irq line", 19'h0, irq_in);
    nb(1'b0);
    st;
    chk("older", wd(g - 2), older);
    chk("newest", wd(g - 1), newest);
    chk("overflow", 19'h1, ovf);
    i_rbsb_host_model.read_data;
    st;
    chk("data ready", 19'h0, drf);
    chk("overflow", 19'h0, ovf);
    chk("strobe", 19'h1, stb_n);
    other_low = 1'b1;
    st;
    chk("line low", 19'h1, line_low);
    other_low = 1'b0;
    $display("test normal done");

    i_rbsb_host_model.freeze;
    n = 0;
    ok = 1'b1;
    while (ok && n < 14) begin
      nb(1'b0);
      if (ok) n = n + 1;
    end
    chk("refused", 19'h0, ok);
    chk("accepted", 19'h1, n >= 8);
    i_rbsb_host_model.unfreeze;
    repeat (14) begin i_rbsb_host_model.read_data; st; end
    chk("newest", wd(g - 1), newest);
    chk("data ready", 19'h0, drf);
    $display("test buffer done");

    dav_mode = `RBSB_MODE_HALF;
    nb(1'b0);
    st;
    chk("half one", 19'h0, drf);
    nb(1'b0);
    st;
    chk("half two", 19'h1, drf);
    i_rbsb_host_model.read_data;
    dav_mode = `RBSB_MODE_NORMAL;
    $display("test half done");

    nb(1'b1);
    st;
    chk("bad count", 19'h1, bad_c);
    nb(1'b1);
    st;
    chk("lock", 19'h0, lock_r);
    chk("lost flag", 19'h1, llf);
    i_rbsb_host_model.read_flags;
    st;
    chk("lost flag", 19'h0, llf);
    $display("test loss done");

    @(negedge clk) nws = 1'b1;
    @(negedge clk) nws = 1'b0;
    st;
    chk("search", 19'h0, {lock_r, ovf});
    dav_mode = `RBSB_MODE_FAST;
    g = 3;
    nb(1'b0);
    st;
    chk("fast d", 19'h0, drf);
    nb(1'b0);
    st;
    chk("lock", 19'h40, {lock_r, good_c});
    chk("fast a", 19'h1, drf);
    chk("fast id", {16'h0, `RBSB_ID_A}, {16'h0, newest[18:16]});
    $display("test fast done");
    give_verdict;
  end
endmodule

`default_nettype wire
